// File: hw/host_bridge_address_decode.sv
/*
 * host_bridge_address_decode: routes memory transactions to dram, pci,
 * interrupt routers or termination; management ram registers;
 * power-on reset sequencing.
 * Assumes srst is the power-good reset, inputs synchronous to core_clk,
 * loose attribute inputs held low after reset.
 */
// What this block does
// (RL1) lowest 512 KB always goes to dram
// (RL2) 80000h-9FFFFh window selectable pci or dram
// (RL3) A0000h-BFFFFh to pci, default management area
// (RL4) C0000h-DFFFFh as eight attributed 16 KB segments
// (RL5) E0000h-EFFFFh four blocks, dram or pci
// (RL6) F0000h-FFFFFh one block, pci after reset
// (RL7) 1 MB to top is dram, optional 15 MB hole
// (RL8) top memory segment caps memory at 256MB
// (RL9) 2 GB to 4 GB forwarded to pci
// (RL10) top 2 MB below 4 GB is boot firmware
// (RL11) interrupt routers at 4 KB steps from FEC00000h
// (RL12) 4 GB to 64 GB terminated, reads zero
// (RL13) shadow reads and writes steered independently
// (RL14) pci accesses to shadowed blocks stay off host
// (RL15) management ram visible in management mode or when open and unlocked
// (RL16) compatible management ram A0000h, non-cacheable
// (RL17) high management ram above 256MB, cacheable alias
// (RL18) top segment up to 1MB cacheable at top
// (RL19) management ram set by registers 72h and 73h
// (RL20) hold pci reset and processor reset at power-on
// (RL21) registers take defaults on reset
// (RL22) assert bus request zero before releasing processor reset
// (RL23) priority: termination, management, shadow, default map
`default_nettype none
`timescale 1ns/1ps

module host_bridge_address_decode
	import bridge_decode_pkg::*;
#(
	parameter int unsigned PCI_SETTLE_CYC_P = bridge_decode_pkg::PCI_SETTLE_CYC
) (
	input  wire logic                       core_clk, // host bus clock
	input  wire logic                       srst, // power-good reset
	input  wire bridge_decode_pkg::req_t    req, // transaction in
	input  wire bridge_decode_pkg::addr_t   installed_top, // top of installed dram
	input  wire logic                       isa_win_dram, // 80000h window to dram
	input  wire logic                       hole_15mb_en, // 15 MB hole to pci
	input  wire logic [12:0]                seg_rd_dram, // shadow read attributes
	input  wire logic [12:0]                seg_wr_dram, // shadow write attributes
	input  wire bridge_decode_pkg::cfg_req_t cfg, // config access
	output bridge_decode_pkg::resp_t        resp_r, // routing answer
	output logic [7:0]                      cfg_rdata_r, // config read data
	output logic                            cfg_ack_r, // config access done
	output logic                            pci_reset_n_r, // pci bus reset
	output logic                            processor_reset_n_r, // processor reset
	output logic                            bus_request_zero_n_r // bus request zero
);

	// sequencing states
	typedef enum logic [1:0] {
		SEQ_PCI_HOLD,
		SEQ_BREQ_SETUP,
		SEQ_BREQ_HOLD,
		SEQ_RUN
	} seq_state_t;

	// configuration registers
	logic [7:0] mgmt_mode_ram_ctrl_r;      // management ram control
	logic [7:0] mgmt_mode_ram_ctrl_nxt;
	logic [7:0] mgmt_mode_ram_ext_ctrl_r;  // management ram extended control
	logic [7:0] mgmt_mode_ram_ext_ctrl_nxt;

	// sequencer state
	seq_state_t           seq_r;           // current phase
	seq_state_t           seq_nxt;
	logic [SEQ_CNT_W-1:0] cnt_r;           // phase cycle counter
	logic [SEQ_CNT_W-1:0] cnt_nxt;

	// decode wires
	addr_t   a; // address under decode
	logic    above_4g; // beyond 32-bit space
	logic    in_dos; // fixed dram area
	logic    in_isa_win; // selectable window
	logic    in_vga; // graphics area
	logic    in_legacy_hi; // A0000h to FFFFFh
	logic    in_ioapic; // interrupt router block
	logic    in_fw; // boot firmware range
	logic    in_hole; // 15 MB hole
	logic    mc_en; // management ram enabled
	logic    mc_lock; // registers locked
	logic    mc_open; // visible outside management mode
	logic    ext_high; // high variant selected
	logic    top_memory_segment_en; // top segment enabled
	logic    mgmt_vis; // management ram visible now
	addr_t   top_cap; // ceiling on main memory
	addr_t   top_lim; // effective top of dram
	addr_t   top_memory_segment_size; // top segment size
	addr_t   top_memory_segment_base; // top segment base
	logic    in_top_memory_segment; // inside top segment
	logic    compat_hit; // compatible management hit
	logic    high_hit; // high management hit
	logic    top_memory_segment_hit; // top segment hit
	logic    mgmt_hit; // any management hit
	logic    sh_range; // shadowable block
	logic    sh_dram; // shadow access to ram
	logic    sh_copy; // block shadowed in ram
	logic    main_dram; // default map dram
	target_t default_tgt; // target from default map
	target_t tgt; // final target
	resp_t   resp_nxt; // answer before its register
	logic    cfg_wr_ctrl; // write to 72h
	logic    cfg_wr_ext; // write to 73h
	logic    hit_set; // sticky hit event
	logic    hit_clr; // sticky hit clear
	logic [7:0] cfg_rdata_nxt; // read mux

	// shadow attribute lookup for C0000h-FFFFFh
	legacy_shadow_attr u_shadow (
		.addr     (a),
		.write    (req.write),
		.rd_dram  (seg_rd_dram),
		.wr_dram  (seg_wr_dram),
		.in_range (sh_range),
		.to_dram  (sh_dram),
		.shadowed (sh_copy)
	);

	// region decode
	assign a            = req.addr;
	assign above_4g     = a >= FOUR_GB; // RL12
	assign in_dos       = a <= DOS_HI; // RL1
	assign in_isa_win   = (a >= ISA_WIN_LO) && (a <= ISA_WIN_HI); // RL2
	assign in_vga       = (a >= VGA_LO) && (a <= VGA_HI); // RL3
	assign in_legacy_hi = (a >= VGA_LO) && (a <= SYSBIOS_HI);
	assign in_ioapic    = (a >= IOAPIC_LO) && (a <= IOAPIC_HI); // RL11
	assign in_fw        = (a >= FW_LO) && (a < FOUR_GB); // RL10
	assign in_hole      = hole_15mb_en && (a >= HOLE_LO) && (a <= HOLE_HI); // RL7

	// management ram controls
	assign mc_en    = mgmt_mode_ram_ctrl_r[MC_EN_BIT]; // RL19
	assign mc_lock  = mgmt_mode_ram_ctrl_r[MC_LOCK_BIT];
	assign mc_open  = mgmt_mode_ram_ctrl_r[MC_OPEN_BIT];
	assign ext_high = mgmt_mode_ram_ext_ctrl_r[EXT_HIGH_BIT];
	assign top_memory_segment_en  = mc_en && mgmt_mode_ram_ext_ctrl_r[EXT_TOP_MEMORY_SEGMENT_BIT];
	assign mgmt_vis = (req.mgmt && !req.from_pci) || (mc_open && !mc_lock); // RL15

	// top of memory: 2 GB ceiling, 256MB with the top segment
	assign top_cap   = top_memory_segment_en ? MGMT_TOP : PCI_LO; // RL8 RL9
	assign top_lim   = (installed_top < top_cap) ? installed_top : top_cap;
	assign top_memory_segment_size = TOP_MEMORY_SEGMENT_UNIT << mgmt_mode_ram_ext_ctrl_r[EXT_SZ_LSB +: 2]; // RL18
	assign top_memory_segment_base = top_lim - top_memory_segment_size;
	assign in_top_memory_segment   = top_memory_segment_en && (a >= top_memory_segment_base) && (a < top_lim);

	// management ram hits
	assign compat_hit = mc_en && !ext_high && mgmt_vis && in_vga;      // RL16
	assign high_hit   = mc_en && ext_high && mgmt_vis && in_legacy_hi; // RL17
	assign top_memory_segment_hit   = in_top_memory_segment && mgmt_vis; // RL18
	assign mgmt_hit   = compat_hit || high_hit || top_memory_segment_hit;

	// default map below 4 GB; hidden top segment goes to pci
	assign main_dram = (a >= ONE_MB) && (a < top_lim) && !in_hole && !in_top_memory_segment; // RL7

	// default target selection
	always_comb begin
		default_tgt = TGT_PCI; // above top, pci space
		if (in_dos) begin
			default_tgt = TGT_DRAM; // RL1
		end else if (in_isa_win) begin
			default_tgt = isa_win_dram ? TGT_DRAM : TGT_PCI; // RL2
		end else if (in_vga) begin
			default_tgt = TGT_PCI; // RL3
		end else if (in_ioapic) begin
			default_tgt = TGT_IOAPIC; // RL11
		end else if (main_dram) begin
			default_tgt = TGT_DRAM; // RL7
		end
	end

	// fixed priority resolution
	always_comb begin
		tgt = default_tgt;
		if (above_4g) begin
			tgt = TGT_TERM; // RL12 RL23
		end else if (mgmt_hit) begin
			tgt = TGT_DRAM; // RL23
		end else if (sh_range) begin
			tgt = sh_dram ? TGT_DRAM : TGT_PCI; // RL13 RL23
		end
	end

	// answer assembly
	always_comb begin
		resp_nxt           = '0;
		resp_nxt.valid     = req.valid;
		resp_nxt.target    = tgt;
		resp_nxt.dram_addr = (high_hit && !above_4g) ? (HIGH_PHYS + a) : a; // RL17
		resp_nxt.cacheable = (tgt == TGT_DRAM) && !(compat_hit && !above_4g); // RL16
		resp_nxt.mgmt_hit  = mgmt_hit && !above_4g;
		resp_nxt.boot_fw   = in_fw; // RL10
		resp_nxt.host_fwd  = !(req.from_pci && sh_range && sh_copy && !mgmt_hit); // RL14
		resp_nxt.unit      = in_ioapic ? a[UNIT_LSB +: 4] : 4'h0; // RL11
	end

	// routing answer register, one cycle after the request
	always_ff @(posedge core_clk) begin
		if (srst) begin
			resp_r <= '0;
		end else begin
			resp_r <= resp_nxt;
		end
	end

	// configuration write decode; lock freezes writes to both registers, hit flag still sets and clears
	assign cfg_wr_ctrl = cfg.wr && (cfg.addr == CFG_MGMT_CTRL) && !mc_lock; // RL19
	assign cfg_wr_ext  = cfg.wr && (cfg.addr == CFG_MGMT_EXT) && !mc_lock;
	assign hit_set     = req.valid && mgmt_hit && !above_4g;
	assign hit_clr     = cfg.wr && (cfg.addr == CFG_MGMT_EXT) && cfg.wdata[EXT_HIT_BIT];

	// control register next value
	always_comb begin
		mgmt_mode_ram_ctrl_nxt = mgmt_mode_ram_ctrl_r;
		if (cfg_wr_ctrl) begin
			mgmt_mode_ram_ctrl_nxt = (mgmt_mode_ram_ctrl_r & ~MGMT_CTRL_WMASK) |
				(cfg.wdata & MGMT_CTRL_WMASK);
		end
	end

	// extended register next value; hit flag set beats its clear
	always_comb begin
		mgmt_mode_ram_ext_ctrl_nxt = mgmt_mode_ram_ext_ctrl_r;
		if (cfg_wr_ext) begin
			mgmt_mode_ram_ext_ctrl_nxt = (mgmt_mode_ram_ext_ctrl_r & ~MGMT_EXT_WMASK) |
				(cfg.wdata & MGMT_EXT_WMASK);
		end
		if (hit_clr) begin
			mgmt_mode_ram_ext_ctrl_nxt[EXT_HIT_BIT] = 1'b0;
		end
		if (hit_set) begin
			mgmt_mode_ram_ext_ctrl_nxt[EXT_HIT_BIT] = 1'b1;
		end
	end

	// read mux, unmapped offsets read zero
	assign cfg_rdata_nxt = (cfg.addr == CFG_MGMT_CTRL) ? mgmt_mode_ram_ctrl_r :
		(cfg.addr == CFG_MGMT_EXT) ? mgmt_mode_ram_ext_ctrl_r : 8'h00;

	// configuration registers load defaults on reset
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mgmt_mode_ram_ctrl_r     <= MGMT_CTRL_RST;  // RL21
			mgmt_mode_ram_ext_ctrl_r <= MGMT_EXT_RST;   // RL21
		end else begin
			mgmt_mode_ram_ctrl_r     <= mgmt_mode_ram_ctrl_nxt;
			mgmt_mode_ram_ext_ctrl_r <= mgmt_mode_ram_ext_ctrl_nxt;
		end
	end

	// configuration answer, one cycle after the access
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cfg_rdata_r <= 8'h00;
			cfg_ack_r   <= 1'b0;
		end else begin
			cfg_rdata_r <= cfg.rd ? cfg_rdata_nxt : 8'h00;
			cfg_ack_r   <= cfg.rd || cfg.wr;
		end
	end

	// power-on phases: pci settle, bus request setup, hold after release
	always_comb begin
		seq_nxt = seq_r;
		cnt_nxt = cnt_r + SEQ_CNT_W'(1);
		unique case (seq_r)
			SEQ_PCI_HOLD: begin
				if (cnt_r == SEQ_CNT_W'(PCI_SETTLE_CYC_P - 1)) begin
					seq_nxt = SEQ_BREQ_SETUP; // RL20
					cnt_nxt = '0;
				end
			end
			SEQ_BREQ_SETUP: begin
				if (cnt_r == SEQ_CNT_W'(BREQ_SETUP_CYC - 1)) begin
					seq_nxt = SEQ_BREQ_HOLD; // RL22
					cnt_nxt = '0;
				end
			end
			SEQ_BREQ_HOLD: begin
				if (cnt_r == SEQ_CNT_W'(BREQ_HOLD_CYC - 1)) begin
					seq_nxt = SEQ_RUN;
					cnt_nxt = '0;
				end
			end
			SEQ_RUN: begin
				cnt_nxt = '0; // idle until next reset
			end
		endcase
	end

	// sequencer state and pins, pins follow the next phase
	always_ff @(posedge core_clk) begin
		if (srst) begin
			seq_r                <= SEQ_PCI_HOLD;
			cnt_r                <= '0;
			pci_reset_n_r        <= 1'b0;           // RL20
			processor_reset_n_r  <= 1'b0;           // RL20
			bus_request_zero_n_r <= 1'b1;
		end else begin
			seq_r                <= seq_nxt;
			cnt_r                <= cnt_nxt;
			pci_reset_n_r        <= (seq_nxt != SEQ_PCI_HOLD);
			processor_reset_n_r  <= (seq_nxt == SEQ_BREQ_HOLD) || (seq_nxt == SEQ_RUN); // RL22
			bus_request_zero_n_r <= !((seq_nxt == SEQ_BREQ_SETUP) ||
				(seq_nxt == SEQ_BREQ_HOLD)); // RL22
		end
	end

endmodule : host_bridge_address_decode

`default_nettype wire

// File: pkg/bridge_decode_pkg.sv
/*
 * bridge_decode_pkg: constants and carriers of the host bridge decoder.
 * Assumes a 36-bit physical address and a 20 MHz core clock.
 */
`default_nettype none

package bridge_decode_pkg;

	// address width and carrier
	localparam int ADDR_W = 36;
	typedef logic [ADDR_W-1:0] addr_t;

	// fixed legacy map below 1 MB
	localparam addr_t DOS_HI      = 36'h0_0007_ffff;
	localparam addr_t ISA_WIN_LO  = 36'h0_0008_0000;
	localparam addr_t ISA_WIN_HI  = 36'h0_0009_ffff;
	localparam addr_t VGA_LO      = 36'h0_000a_0000;
	localparam addr_t VGA_HI      = 36'h0_000b_ffff;
	localparam addr_t ADDIN_LO    = 36'h0_000c_0000;
	localparam addr_t ADDIN_HI    = 36'h0_000d_ffff;
	localparam addr_t EXTBIOS_LO  = 36'h0_000e_0000;
	localparam addr_t EXTBIOS_HI  = 36'h0_000e_ffff;
	localparam addr_t SYSBIOS_LO  = 36'h0_000f_0000;
	localparam addr_t SYSBIOS_HI  = 36'h0_000f_ffff;
	localparam int    SEG_SHIFT   = 14;
	localparam int    SEG_COUNT   = 13;
	localparam int    ADDIN_SEGS  = 8;

	// extended memory map
	localparam addr_t ONE_MB      = 36'h0_0010_0000;
	localparam addr_t HOLE_LO     = 36'h0_00f0_0000;
	localparam addr_t HOLE_HI     = 36'h0_00ff_ffff;
	localparam addr_t MGMT_TOP    = 36'h0_1000_0000;
	localparam addr_t PCI_LO      = 36'h0_8000_0000;
	localparam addr_t IOAPIC_LO   = 36'h0_fec0_0000;
	localparam addr_t IOAPIC_HI   = 36'h0_fec0_ffff;
	localparam addr_t FW_LO       = 36'h0_ffe0_0000;
	localparam addr_t FOUR_GB     = 36'h1_0000_0000;
	localparam addr_t HIGH_PHYS   = 36'h0_1000_0000;
	localparam addr_t TOP_MEMORY_SEGMENT_UNIT   = 36'h0_0002_0000;
	localparam int    UNIT_LSB    = 12;

	// configuration registers
	localparam logic [7:0] CFG_MGMT_CTRL   = 8'h72;
	localparam logic [7:0] CFG_MGMT_EXT    = 8'h73;
	localparam logic [7:0] MGMT_CTRL_RST   = 8'h02;
	localparam logic [7:0] MGMT_EXT_RST    = 8'h00;
	localparam logic [7:0] MGMT_CTRL_WMASK = 8'h58;
	localparam logic [7:0] MGMT_EXT_WMASK  = 8'h87;
	localparam int MC_EN_BIT    = 3;
	localparam int MC_LOCK_BIT  = 4;
	localparam int MC_OPEN_BIT  = 6;
	localparam int EXT_TOP_MEMORY_SEGMENT_BIT = 0;
	localparam int EXT_SZ_LSB   = 1;
	localparam int EXT_HIT_BIT  = 5;
	localparam int EXT_HIGH_BIT = 7;

	// power-on sequencing times
	localparam int CLK_PERIOD_NS  = 50;
	localparam int PCI_SETTLE_NS  = 1000000;
	localparam int BREQ_SETUP_NS  = 200;
	localparam int BREQ_HOLD_NS   = 200;
	localparam int PCI_SETTLE_CYC = (PCI_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BREQ_SETUP_CYC = (BREQ_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BREQ_HOLD_CYC  = (BREQ_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SEQ_CNT_W      = 20;

	// routing destinations
	typedef enum logic [1:0] {
		TGT_DRAM,
		TGT_PCI,
		TGT_IOAPIC,
		TGT_TERM
	} target_t;

	// transaction presented for decode
	typedef struct packed {
		logic  valid;
		logic  write;
		logic  mgmt;
		logic  from_pci;
		addr_t addr;
	} req_t;

	// routing answer
	typedef struct packed {
		logic    valid;
		target_t target;
		addr_t   dram_addr;
		logic    cacheable;
		logic    mgmt_hit;
		logic    boot_fw;
		logic    host_fwd;
		logic    [3:0] unit;
	} resp_t;

	// configuration access
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cfg_req_t;

endpackage : bridge_decode_pkg

`default_nettype wire

// File: hw/legacy_shadow_attr.sv
/*
 * legacy_shadow_attr: per-block read and write steering over the thirteen
 * shadowable blocks from C0000h to FFFFFh.
 * Assumes attribute inputs are static between transactions.
 */
`default_nettype none
`timescale 1ns/1ps

module legacy_shadow_attr
	import bridge_decode_pkg::*;
(
	input  wire bridge_decode_pkg::addr_t addr, // transaction address
	input  wire logic                     write, // write access
	input  wire logic [12:0]              rd_dram, // per block: reads hit ram
	input  wire logic [12:0]              wr_dram, // per block: writes hit ram
	output logic                          in_range,   // address is shadowable
	output logic                          to_dram,    // this access goes to ram
	output logic                          shadowed    // block holds a ram copy
);

	logic [SEG_COUNT-1:0] seg_hit;   // one-hot block match

	// block lower bounds: eight add-in, four extended, one system block
	genvar i;
	generate
		for (i = 0; i < SEG_COUNT; i++) begin : g_seg
			localparam addr_t SEG_LO = (i == SEG_COUNT - 1) ? SYSBIOS_LO :
				ADDIN_LO + (addr_t'(i) << SEG_SHIFT);
			localparam addr_t SEG_HI = (i == SEG_COUNT - 1) ? SYSBIOS_HI :
				SEG_LO + (addr_t'(1) << SEG_SHIFT) - addr_t'(1);
			assign seg_hit[i] = (addr >= SEG_LO) && (addr <= SEG_HI); // RL4 RL5 RL6
		end
	endgenerate

	// separate read and write steering
	assign in_range = |seg_hit;
	assign to_dram  = write ? |(seg_hit & wr_dram) : |(seg_hit & rd_dram); // RL13
	assign shadowed = |(seg_hit & rd_dram);

endmodule : legacy_shadow_attr

`default_nettype wire

// File: verif/proc_agent_model.sv
/* proc_agent_model: processor agent taking its identity from bus
 * request zero as its reset ends. Assumes registered inputs. */
`timescale 1ns/1ps
`default_nettype none
module proc_agent_model (
	input  wire logic       core_clk,           // host bus clock
	input  wire logic       processor_reset_n,  // reset from the bridge
	input  wire logic       bus_request_zero_n, // request line seen by this agent
	output logic      [1:0] agent_id            // 3 while held in reset
);
	logic rst_q; // last sampled reset level

	// identity latched on the edge that first sees reset released
	always_ff @(posedge core_clk) begin
		rst_q <= processor_reset_n;
		if (!processor_reset_n) agent_id <= 2'd3;
		else if (!rst_q) agent_id <= bus_request_zero_n ? 2'd1 : 2'd0;
	end
endmodule : proc_agent_model
`default_nettype wire

// File: verif/host_bridge_address_decode_assertions.sv
/* host_bridge_address_decode_assertions: decoder port properties.
 * Assumes one clock, srst sync high. */
`timescale 1ns/1ps
`default_nettype none
module host_bridge_address_decode_assertions #(
	parameter int unsigned PCI_SETTLE_CYC_P = 8  // settle count of the dut
) (
	input wire logic                        core_clk,
	input wire logic                        srst,
	input wire bridge_decode_pkg::req_t     req,
	input wire logic                        isa_win_dram,
	input wire bridge_decode_pkg::cfg_req_t cfg,
	input wire bridge_decode_pkg::resp_t    resp_r,
	input wire logic                        cfg_ack_r,
	input wire logic                        pci_reset_n_r,
	input wire logic                        processor_reset_n_r,
	input wire logic                        bus_request_zero_n_r
);
	import bridge_decode_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	logic [19:0] up_r;  // cycles since reset release, saturating

	// release counter for the settle time
	always_ff @(posedge core_clk) begin
		if (srst) up_r <= '0;
		else if (up_r != 20'hfffff) up_r <= up_r + 20'h1;
	end

	// interrupt router unit carried from address nibble
	property p_unit;
		logic [3:0] u;
		(req.valid && req.addr[35:16] == 20'h0fec0, u = req.addr[15:12])
			|=> resp_r.target == TGT_IOAPIC && resp_r.unit == u;
	endproperty
	AST_DOS: assert property (req.valid && req.addr <= DOS_HI
		|=> resp_r.target == TGT_DRAM && resp_r.dram_addr == $past(req.addr))
		else $error("low area not routed to dram");
	AST_ISA: assert property (req.valid && req.addr >= ISA_WIN_LO && req.addr <= ISA_WIN_HI
		|=> resp_r.target == ($past(isa_win_dram) ? TGT_DRAM : TGT_PCI))
		else $error("isa window routed wrongly");
	AST_PCI_HI: assert property (req.valid && req.addr >= PCI_LO && req.addr < FW_LO
		&& req.addr[35:16] != 20'h0fec0 |=> resp_r.target == TGT_PCI)
		else $error("upper space not sent to pci");
	AST_BOOT: assert property (req.valid && req.addr >= FW_LO && req.addr < FOUR_GB
		|=> resp_r.boot_fw && resp_r.target == TGT_PCI) else $error("boot area not flagged");
	AST_IOAPIC: assert property (p_unit) else $error("router unit wrong");
	AST_TERM: assert property (req.valid && req.addr >= FOUR_GB
		|=> resp_r.valid && resp_r.target == TGT_TERM) else $error("high access not terminated");
	AST_ACK: assert property (1'b1
		|=> cfg_ack_r == ($past(cfg.wr) || $past(cfg.rd))) else $error("config ack wrong");
	AST_PCI_FIRST: assert property (!pci_reset_n_r
		|-> !processor_reset_n_r && bus_request_zero_n_r) else $error("reset order broken");
	AST_SETTLE: assert property ($rose(pci_reset_n_r)
		|-> up_r >= PCI_SETTLE_CYC_P && up_r <= PCI_SETTLE_CYC_P + 1)
		else $error("pci reset released at wrong time");
	AST_BREQ: assert property ($rose(processor_reset_n_r)
		|-> !$past(bus_request_zero_n_r, 4) ##4 $rose(bus_request_zero_n_r))
		else $error("bus request order wrong");
	COV_TERM: cover property (req.valid && req.addr >= FOUR_GB);
	COV_MGMT: cover property (resp_r.valid && resp_r.mgmt_hit);
	COV_BOOT: cover property ($rose(processor_reset_n_r));
	COV_CFG: cover property (cfg.wr && cfg.addr == CFG_MGMT_CTRL);
endmodule : host_bridge_address_decode_assertions
bind host_bridge_address_decode host_bridge_address_decode_assertions #(
	.PCI_SETTLE_CYC_P(PCI_SETTLE_CYC_P)
) u_chk (
	.core_clk(core_clk), .srst(srst), .req(req), .isa_win_dram(isa_win_dram), .cfg(cfg),
	.resp_r(resp_r), .cfg_ack_r(cfg_ack_r), .pci_reset_n_r(pci_reset_n_r),
	.processor_reset_n_r(processor_reset_n_r), .bus_request_zero_n_r(bus_request_zero_n_r)
);
`default_nettype wire

// File: verif/host_bridge_address_decode_tb.sv
/* host_bridge_address_decode_tb: decode traffic vs a behavioural map,
 * management ram phases, power-on order.
 * Assumes checker and agent model compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module host_bridge_address_decode_tb;
	import bridge_decode_pkg::*;
	localparam int SETTLE = 8;  // shortened settle count
	localparam logic [7:0] MCV [6] = '{8'h00, 8'h08, 8'h08, 8'h08, 8'h48, 8'h58};
	localparam logic [7:0] EXV [6] = '{8'h00, 8'h00, 8'h80, 8'h01, 8'h05, 8'h87};
	localparam addr_t TOPS [4] = '{36'h0_0400_0000, 36'h0_1000_0000, 36'h0_2000_0000,
		36'h0_c000_0000};
	localparam addr_t BASES [16] = '{36'h0, 36'h7_0000, ISA_WIN_LO, VGA_LO, 36'hb_0000,
		ADDIN_LO, 36'hd_0000, EXTBIOS_LO, SYSBIOS_LO, HOLE_LO, 36'h0, IOAPIC_LO, FW_LO,
		PCI_LO, FOUR_GB, 36'hf_fff0_0000};
	logic        core_clk = 1'b0; // 20 MHz clock
	logic        srst = 1'b1; // reset, held at start
	req_t        req = '0; // decode request
	addr_t       installed_top = TOPS[0];
	logic        isa_win_dram = 1'b0;
	logic        hole_15mb_en = 1'b0;
	logic [12:0] seg_rd_dram = '0;
	logic [12:0] seg_wr_dram = '0;
	cfg_req_t    cfg = '0; // config access
	resp_t       resp_r;
	logic  [7:0] cfg_rdata_r;
	logic        cfg_ack_r;
	logic        pci_reset_n_r;
	logic        processor_reset_n_r;
	logic        bus_request_zero_n_r;
	logic  [1:0] agent_id; // identity taken by the agent
	int          err_count = 0;
	int          num_checks = 0;
	logic [31:0] rng = 32'd574; // xorshift state
	logic  [7:0] mc = MGMT_CTRL_RST; // model of 72h
	logic  [7:0] ext = MGMT_EXT_RST; // model of 73h

	// free running clock
	always #25 core_clk = ~core_clk;

	host_bridge_address_decode #(.PCI_SETTLE_CYC_P(SETTLE)) dut (
		.core_clk(core_clk), .srst(srst), .req(req), .installed_top(installed_top),
		.isa_win_dram(isa_win_dram), .hole_15mb_en(hole_15mb_en), .seg_rd_dram(seg_rd_dram),
		.seg_wr_dram(seg_wr_dram), .cfg(cfg), .resp_r(resp_r), .cfg_rdata_r(cfg_rdata_r),
		.cfg_ack_r(cfg_ack_r), .pci_reset_n_r(pci_reset_n_r),
		.processor_reset_n_r(processor_reset_n_r), .bus_request_zero_n_r(bus_request_zero_n_r));
	proc_agent_model agent0 (.core_clk(core_clk), .processor_reset_n(processor_reset_n_r),
		.bus_request_zero_n(bus_request_zero_n_r), .agent_id(agent_id));

	// xorshift generator
	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : rnd

	// usable memory top, capped by the top segment
	function automatic addr_t top_lim();
		addr_t l;
		l = (installed_top < PCI_LO) ? installed_top : PCI_LO;
		if (mc[MC_EN_BIT] && ext[EXT_TOP_MEMORY_SEGMENT_BIT] && l > MGMT_TOP) l = MGMT_TOP;
		return l;
	endfunction : top_lim

	// expected answer for one request
	function automatic resp_t model(input req_t r);
		resp_t e;
		addr_t a;
		addr_t lim;
		logic  vis;
		logic  cmp;
		logic  sh;
		int    b;
		a = r.addr;
		lim = top_lim();
		e = '0;
		e.valid = r.valid;
		e.dram_addr = a;
		e.unit = a[15:12];
		vis = (r.mgmt && !r.from_pci) || (mc[MC_OPEN_BIT] && !mc[MC_LOCK_BIT]);
		cmp = mc[MC_EN_BIT] && !ext[EXT_HIGH_BIT] && a >= VGA_LO && a <= VGA_HI && vis;
		sh = a >= ADDIN_LO && a <= SYSBIOS_HI;
		b = !sh ? 0 : (a < SYSBIOS_LO) ? int'(a[19:14]) - 48 : 12;
		if (a >= FOUR_GB) e.target = TGT_TERM;
		else if (cmp) e.mgmt_hit = 1'b1;
		else if (mc[MC_EN_BIT] && ext[EXT_HIGH_BIT] && a >= VGA_LO && a <= SYSBIOS_HI && vis) begin
			e.mgmt_hit = 1'b1;
			e.dram_addr = a + HIGH_PHYS;
		end else if (mc[MC_EN_BIT] && ext[0] && a >= lim - (TOP_MEMORY_SEGMENT_UNIT << ext[2:1]) && a < lim) begin
			e.mgmt_hit = vis;
			e.target = vis ? TGT_DRAM : TGT_PCI;
		end else if (sh) e.target = (r.write ? seg_wr_dram[b] : seg_rd_dram[b]) ? TGT_DRAM : TGT_PCI;
		else if (a <= DOS_HI) e.target = TGT_DRAM;
		else if (a <= ISA_WIN_HI) e.target = isa_win_dram ? TGT_DRAM : TGT_PCI;
		else if (a < ONE_MB) e.target = TGT_PCI;
		else if (a[35:16] == 20'h0fec0) e.target = TGT_IOAPIC;
		else if (a < lim && !(hole_15mb_en && a >= HOLE_LO && a <= HOLE_HI)) e.target = TGT_DRAM;
		else e.target = TGT_PCI;
		e.cacheable = e.target == TGT_DRAM && !cmp;
		e.boot_fw = a >= FW_LO && a < FOUR_GB;
		e.host_fwd = !(r.from_pci && sh && seg_rd_dram[b] && !e.mgmt_hit);
		return e;
	endfunction : model

	// compare and count
	task automatic check_val(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check_val

	// one decode request, answer checked one cycle later
	task automatic step(input req_t r);
		resp_t e;
		resp_t s;
		e = model(r);
		req = r;
		@(posedge core_clk);
		if (r.valid && e.mgmt_hit) ext[EXT_HIT_BIT] = 1'b1;
		#1;
		s = resp_r;
		if (e.target != TGT_DRAM) s.dram_addr = e.dram_addr;
		if (e.target != TGT_IOAPIC) s.unit = e.unit;
		if (!r.valid) s[45:0] = e[45:0];
		check_val(64'(s), 64'(e));
	endtask : step

	// random request over the interesting regions
	function automatic req_t rand_req();
		req_t        r;
		logic [31:0] v;
		v = rnd();
		r = '0;
		r.valid = v[0] | v[1];
		r.write = v[2];
		r.mgmt = v[3];
		r.from_pci = v[4];
		r.addr = ((v[11:8] == 4'd10) ? top_lim() - 36'h4_0000 : BASES[v[11:8]])
			+ 36'(rnd() & 32'h3ffff);
		return r;
	endfunction : rand_req

	// one config access, idle cycle after it
	task automatic cfg_acc(input logic wr, input logic [7:0] ad, input logic [7:0] wd);
		logic [7:0] e;
		e = wr ? 8'h00 : (ad == CFG_MGMT_CTRL) ? mc : (ad == CFG_MGMT_EXT) ? ext : 8'h00;
		req = '0;
		cfg = '{wr, !wr, ad, wd};
		@(posedge core_clk);
		#1;
		check_val(64'(cfg_ack_r), 64'd1);
		check_val(64'(cfg_rdata_r), 64'(e));
		if (wr && ad == CFG_MGMT_EXT) begin
			if (!mc[MC_LOCK_BIT]) ext = (ext & ~MGMT_EXT_WMASK) | (wd & MGMT_EXT_WMASK);
			if (wd[EXT_HIT_BIT]) ext[EXT_HIT_BIT] = 1'b0;
		end
		if (wr && ad == CFG_MGMT_CTRL && !mc[MC_LOCK_BIT])
			mc = (mc & ~MGMT_CTRL_WMASK) | (wd & MGMT_CTRL_WMASK);
		cfg = '0;
		@(posedge core_clk);
		#1;
		check_val(64'(cfg_ack_r), 64'd0);
	endtask : cfg_acc

	// verdict and end of run
	task automatic report_and_stop();
		if (err_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	// main sequence
	initial begin
		repeat (12) @(posedge core_clk);
		#1;
		srst = 1'b0;
		check_val(64'(pci_reset_n_r), 64'd0);
		check_val(64'(processor_reset_n_r), 64'd0);
		cfg_acc(1'b0, CFG_MGMT_CTRL, 8'h00);
		cfg_acc(1'b0, CFG_MGMT_EXT, 8'h00);
		for (int i = 0; i < 40 && processor_reset_n_r !== 1'b1; i++) begin
			@(posedge core_clk);
			#1;
		end
		check_val(64'(pci_reset_n_r), 64'd1);
		check_val(64'(bus_request_zero_n_r), 64'd0);
		for (int p = 0; p < 6; p++) begin
			cfg_acc(1'b1, CFG_MGMT_CTRL, MCV[p]);
			cfg_acc(1'b1, CFG_MGMT_EXT, EXV[p]);
			if (p == 5) cfg_acc(1'b1, CFG_MGMT_CTRL, 8'h00);
			cfg_acc(1'b0, CFG_MGMT_CTRL, 8'h00);
			cfg_acc(1'b0, 8'h74, 8'h00);
			installed_top = TOPS[rnd() % 32'd4];
			{isa_win_dram, hole_15mb_en, seg_rd_dram, seg_wr_dram} = 28'(rnd());
			repeat (80) step(rand_req());
			cfg_acc(1'b0, CFG_MGMT_EXT, 8'h00);
			cfg_acc(1'b1, CFG_MGMT_EXT, EXV[p] | 8'h20);
		end
		check_val(64'(agent_id), 64'd0);
		report_and_stop();
	end

	// hang guard
	initial begin
		repeat (5000) @(posedge core_clk);
		err_count++;
		report_and_stop();
	end
endmodule : host_bridge_address_decode_tb
`default_nettype wire
